// file: src/pbd_defines.svh
// Constants of the parameter block command unit
`ifndef PBD_DEFINES_SVH
`define PBD_DEFINES_SVH

// ==============================
// Address map
`define PBD_RAM_HI 16'h1fff
`define PBD_FW_TOP 13'h00ff
`define PBD_WIN_BITS 13
`define PBD_WIN_BASE 20'h00000
`define PBD_CH0_PB 16'h0100
`define PBD_CH1_PB 16'h0140
`define PBD_MISC_A_LO 16'hffc0
`define PBD_MISC_A_HI 16'hffc6
`define PBD_MISC_B_LO 16'hfff0
`define PBD_MISC_B_HI 16'hfffe
`define PBD_TMR_LO 16'hffc8
`define PBD_TMR_HI 16'hffce
`define PBD_TMR_CTL 2'h3
`define PBD_TMR_RSV 2'h0

// ==============================
// Parameter block layout
`define PBD_PB_CMD 5'h00
`define PBD_PB_STAT 5'h01
`define PBD_PB_CHAIN 5'h02
`define PBD_PB_SDEV 5'h04
`define PBD_PB_STYPE 5'h05
`define PBD_PB_SREG 5'h06
`define PBD_PB_SDATA 5'h08
`define PBD_PB_DDEV 5'h0a
`define PBD_PB_DTYPE 5'h0b
`define PBD_PB_DREG 5'h0c
`define PBD_PB_DPTR 5'h0e
`define PBD_PB_CNT 5'h10
`define PBD_PB_LAST 5'h12

// ==============================
// Commands and status
`define PBD_CMD_CHECK 8'h00
`define PBD_CMD_RWR 8'h01
`define PBD_CMD_RRD 8'h02
`define PBD_CMD_DMA 8'h03
`define PBD_CMD_TASK 8'h04
`define PBD_ST_OK 8'h01
`define PBD_ST_BADCMD 8'h80
`define PBD_ST_REFUSED 8'h81

// ==============================
// Timer control byte and clock periods
`define PBD_CTL_BCD 2
`define PBD_CTL_CSEL 4:3
`define PBD_CLK_NS 25
`define PBD_TCK_F_NS 800
`define PBD_TCK_M_NS 1600
`define PBD_TCK_S_NS 3200

`endif

// file: src/pbd_pkg.sv
// Types shared by the parameter block command unit
`default_nettype none
package pbd_pkg;
	typedef enum logic [3:0] {
		ST_IDLE, ST_FETCH, ST_DECODE, ST_REG_RD, ST_REG_WR,
		ST_DMA_PICK, ST_DMA_RD, ST_DMA_WR, ST_TASK, ST_STATUS
	} pbd_state_e;

	typedef enum logic [1:0] {TGT_RAM, TGT_TMR, TGT_BUS} pbd_tgt_e;

	typedef struct packed {
		logic [19:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
	} pbd_host_req_s;

	typedef struct packed {
		logic [15:0] addr;
		logic io;
		logic misc;
		logic wr;
		logic [7:0] wdata;
	} pbd_lbus_req_s;
endpackage
`default_nettype wire

// file: src/pbd_ram.sv
// Dual-port byte RAM with registered read data
`default_nettype none
module pbd_ram #(
	parameter int AW = 13,
	parameter int DW = 8
) (
	input wire logic sys_clk_i,
	input wire logic a_en_i,
	input wire logic a_we_i,
	input wire logic [AW-1:0] a_addr_i,
	input wire logic [DW-1:0] a_wdata_i,
	output logic [DW-1:0] a_rdata_o,
	input wire logic b_en_i,
	input wire logic b_we_i,
	input wire logic [AW-1:0] b_addr_i,
	input wire logic [DW-1:0] b_wdata_i,
	output logic [DW-1:0] b_rdata_o
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// ==============================
	// One writer process for the array; port B wins a same-address write in one cycle
	always_ff @(posedge sys_clk_i) begin
		if (a_en_i && a_we_i) mem[a_addr_i] <= a_wdata_i;
		if (b_en_i && b_we_i) mem[b_addr_i] <= b_wdata_i;
	end

	// Registered read data on both ports
	always_ff @(posedge sys_clk_i) begin
		if (a_en_i) a_rdata_o <= mem[a_addr_i];
		if (b_en_i) b_rdata_o <= mem[b_addr_i];
	end
endmodule
`default_nettype wire

// file: src/pbd_skid.sv
// Two-entry buffer between DMA source reads and destination writes
`default_nettype none
module pbd_skid #(
	parameter int W = 8
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	logic [1:0] cnt_reg;
	logic [W-1:0] d1_reg;
	logic push;
	logic pop;

	// ==============================
	// Handshake; a full buffer stalls the reading side
	assign in_ready_o = (cnt_reg != 2'h2);
	assign out_valid_o = (cnt_reg != 2'h0);
	assign push = in_valid_i && in_ready_o;
	assign pop = out_ready_i && out_valid_o;

	// Occupancy
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) cnt_reg <= 2'h0;
		else cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
	end

	// Head entry is the output register, second entry backs it up
	always_ff @(posedge sys_clk_i) begin
		if (pop) out_data_o <= (cnt_reg == 2'h2) ? d1_reg : in_data_i;
		else if (push && cnt_reg == 2'h0) out_data_o <= in_data_i;
		if (push && !pop && cnt_reg == 2'h1) d1_reg <= in_data_i;
	end
endmodule
`default_nettype wire

// file: src/pbd_cmd_unit.sv
// Parameter block command unit: window, decode, command engine and counters
`include "pbd_defines.svh"
`default_nettype none
module pbd_cmd_unit #(
	parameter logic [19:0] WIN_BASE = `PBD_WIN_BASE,
	parameter logic [15:0] CH0_PB = `PBD_CH0_PB,
	parameter logic [15:0] CH1_PB = `PBD_CH1_PB
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire pbd_pkg::pbd_host_req_s host_i,
	output logic host_hit_o,
	output logic [7:0] host_rdata_o,
	input wire logic [1:0] chan_start_i,
	input wire logic [1:0] irq_ack_i,
	output logic [1:0] host_irq_o,
	output logic lbus_req_o,
	output pbd_pkg::pbd_lbus_req_s lbus_o,
	input wire logic lbus_ack_i,
	input wire logic [7:0] lbus_rdata_i,
	input wire logic dma_term_i,
	output logic task_run_o,
	output logic [15:0] task_addr_o,
	input wire logic task_done_i,
	output logic [2:0] tmr_out_o,
	output logic busy_o
);
	localparam int F_CYC = `PBD_TCK_F_NS / `PBD_CLK_NS;
	localparam int M_CYC = `PBD_TCK_M_NS / `PBD_CLK_NS;
	localparam int S_CYC = `PBD_TCK_S_NS / `PBD_CLK_NS;
	localparam int PW = $clog2(S_CYC);

	// ==============================
	// Functions
	function automatic pbd_pkg::pbd_tgt_e tgt_of(input logic io, input logic [15:0] a);
		if (!io && a <= `PBD_RAM_HI) return pbd_pkg::TGT_RAM;
		if (io && a >= `PBD_TMR_LO && a <= `PBD_TMR_HI) return pbd_pkg::TGT_TMR;
		return pbd_pkg::TGT_BUS;
	endfunction

	function automatic logic [15:0] dec16(input logic [15:0] v, input logic bcd);
		logic [15:0] r;
		logic brw;
		r = v - 16'h0001;
		if (bcd) begin
			r = v;
			brw = 1'b1;
			for (int d = 0; d < 4; d++) begin
				if (brw) begin
					if (r[d*4+:4] == 4'h0) r[d*4+:4] = 4'h9;
					else begin
						r[d*4+:4] = r[d*4+:4] - 4'h1;
						brw = 1'b0;
					end
				end
			end
		end
		return r;
	endfunction

	function automatic logic [15:0] w16(input logic [7:0] lo, input logic [7:0] hi);
		return {hi, lo};
	endfunction

	// ==============================
	// State
	pbd_pkg::pbd_state_e state_reg;
	logic [7:0] pb_reg [0:`PBD_PB_LAST];
	logic [4:0] idx_reg;
	logic [15:0] pb_base_reg;
	logic chan_reg, last_reg, k_reg, unl_reg, term_seen_reg, ram_pend_reg;
	logic [7:0] status_reg, xfer_reg;
	logic [23:0] cnt_reg;
	logic [15:0] saddr_reg, daddr_reg;
	logic [1:0] pend_reg, irq_reg;
	logic [2:0] term_sync_reg;
	logic term_lvl_reg;

	// ==============================
	// Terminate pin: three stages, level accepted when stages two and three agree
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			term_sync_reg <= 3'h0;
			term_lvl_reg <= 1'b0;
		end else begin
			term_sync_reg <= {term_sync_reg[1:0], dma_term_i};
			if (term_sync_reg[2] == term_sync_reg[1]) term_lvl_reg <= term_sync_reg[2];
		end
	end

	// ==============================
	// Host window onto the dual-port RAM
	logic host_fw, ram_a_en, ram_a_we;
	assign host_hit_o = host_i.addr[19:`PBD_WIN_BITS] == WIN_BASE[19:`PBD_WIN_BITS];
	assign host_fw = host_i.addr[`PBD_WIN_BITS-1:0] <= `PBD_FW_TOP;
	assign ram_a_en = host_hit_o && (host_i.rd || host_i.wr);
	assign ram_a_we = host_i.wr && !host_fw; // Firmware area kept from host

	// ==============================
	// Parameter block fields
	logic in_idle, in_fetch, in_stat, in_rrd, in_rwr, in_drd, in_dwr, in_task, in_dma;
	logic src_io, dst_io, rd_cmd, word_op, rd_more, chain_go, pick1, take;
	logic [15:0] src_addr, dst_addr, chain_ptr;
	logic [4:0] data_idx;
	assign in_idle = state_reg == pbd_pkg::ST_IDLE;
	assign in_fetch = state_reg == pbd_pkg::ST_FETCH;
	assign in_stat = state_reg == pbd_pkg::ST_STATUS;
	assign in_rrd = state_reg == pbd_pkg::ST_REG_RD;
	assign in_rwr = state_reg == pbd_pkg::ST_REG_WR;
	assign in_drd = state_reg == pbd_pkg::ST_DMA_RD;
	assign in_dwr = state_reg == pbd_pkg::ST_DMA_WR;
	assign in_task = state_reg == pbd_pkg::ST_TASK;
	assign in_dma = in_drd || in_dwr || state_reg == pbd_pkg::ST_DMA_PICK;
	// Device 0 means local memory, any other number an I/O register
	assign src_io = pb_reg[`PBD_PB_SDEV] != 8'h00;
	assign dst_io = pb_reg[`PBD_PB_DDEV] != 8'h00;
	assign src_addr = w16(pb_reg[`PBD_PB_SREG], pb_reg[`PBD_PB_SREG+5'h01]);
	assign dst_addr = dst_io ? w16(pb_reg[`PBD_PB_DREG], pb_reg[`PBD_PB_DREG+5'h01])
		: w16(pb_reg[`PBD_PB_DPTR], pb_reg[`PBD_PB_DPTR+5'h01]);
	assign chain_ptr = w16(pb_reg[`PBD_PB_CHAIN], pb_reg[`PBD_PB_CHAIN+5'h01]);
	assign rd_cmd = pb_reg[`PBD_PB_CMD] == `PBD_CMD_RRD;
	assign word_op = rd_cmd ? pb_reg[`PBD_PB_STYPE][0] : pb_reg[`PBD_PB_DTYPE][0];
	assign data_idx = `PBD_PB_SDATA + {4'h0, k_reg};
	// Null or firmware-area link ends the chain
	assign chain_go = chain_ptr > {3'h0, `PBD_FW_TOP};
	// Unlimited transfer runs until terminate
	assign rd_more = (unl_reg || cnt_reg != 24'h0) && !term_seen_reg && !term_lvl_reg;

	// ==============================
	// Local access path shared by the fetch, status, register and DMA states
	logic acc_req, acc_io, acc_wr, acc_done, acc_ok, acc_refuse, tmr_ctl;
	logic [15:0] acc_addr;
	logic [7:0] acc_wdata, acc_rdata, ram_b_rdata, tmr_rdata, buf_data;
	logic [1:0] tsel;
	pbd_pkg::pbd_tgt_e acc_tgt;
	logic buf_in_ready, buf_out_valid, buf_push, buf_pop;
	assign acc_req = in_fetch || in_stat || in_rrd || in_rwr || in_drd || in_dwr;
	assign acc_wr = in_stat || in_rwr || in_dwr;
	assign acc_io = (in_rrd || in_drd) ? src_io
		: in_rwr ? (!rd_cmd && dst_io) : in_dwr ? dst_io : 1'b0;
	assign acc_addr = in_fetch ? pb_base_reg + {11'h000, idx_reg}
		: in_stat ? pb_base_reg + {11'h000, `PBD_PB_STAT}
		: in_rrd ? src_addr + {15'h0000, k_reg}
		: in_rwr ? (rd_cmd ? pb_base_reg + {11'h000, data_idx}
			: dst_addr + {15'h0000, k_reg})
		: in_drd ? saddr_reg : daddr_reg;
	assign acc_wdata = in_stat ? status_reg
		: in_rwr ? (rd_cmd ? xfer_reg : pb_reg[data_idx]) : buf_data;
	assign acc_tgt = tgt_of(acc_io, acc_addr);
	assign tsel = acc_addr[2:1];
	assign tmr_ctl = tsel == `PBD_TMR_CTL;
	// Counter 0 and its mode are firmware property
	assign acc_refuse = acc_req && acc_tgt == pbd_pkg::TGT_TMR && (tsel == `PBD_TMR_RSV
		|| (tmr_ctl && acc_wr && acc_wdata[1:0] == `PBD_TMR_RSV));
	assign acc_done = acc_req && (acc_tgt == pbd_pkg::TGT_RAM ? (acc_wr || ram_pend_reg)
		: acc_tgt == pbd_pkg::TGT_TMR ? 1'b1 : lbus_ack_i);
	assign acc_ok = acc_done && !acc_refuse;
	assign acc_rdata = acc_tgt == pbd_pkg::TGT_RAM ? ram_b_rdata
		: acc_tgt == pbd_pkg::TGT_TMR ? tmr_rdata : lbus_rdata_i;

	// Local bus request; misc device block flagged for its own select
	assign lbus_req_o = acc_req && acc_tgt == pbd_pkg::TGT_BUS;
	assign lbus_o.addr = acc_addr;
	assign lbus_o.io = acc_io;
	assign lbus_o.wr = acc_wr;
	assign lbus_o.wdata = acc_wdata;
	assign lbus_o.misc = acc_io && ((acc_addr >= `PBD_MISC_A_LO && acc_addr <= `PBD_MISC_A_HI)
		|| (acc_addr >= `PBD_MISC_B_LO && acc_addr <= `PBD_MISC_B_HI));

	// RAM read data arrives one cycle after the address
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) ram_pend_reg <= 1'b0;
		else ram_pend_reg <= acc_req && acc_tgt == pbd_pkg::TGT_RAM && !acc_wr && !ram_pend_reg;
	end

	pbd_ram #(.AW(`PBD_WIN_BITS), .DW(8)) u_ram (
		.sys_clk_i(sys_clk_i),
		.a_en_i(ram_a_en),
		.a_we_i(ram_a_we),
		.a_addr_i(host_i.addr[`PBD_WIN_BITS-1:0]),
		.a_wdata_i(host_i.wdata),
		.a_rdata_o(host_rdata_o),
		.b_en_i(acc_req && acc_tgt == pbd_pkg::TGT_RAM && !ram_pend_reg),
		.b_we_i(acc_wr),
		.b_addr_i(acc_addr[`PBD_WIN_BITS-1:0]),
		.b_wdata_i(acc_wdata),
		.b_rdata_o(ram_b_rdata)
	);

	// ==============================
	// DMA buffer: reads stall while it is full, so no word is dropped
	assign buf_push = in_drd && acc_ok;
	assign buf_pop = in_dwr && acc_ok;
	pbd_skid #(.W(8)) u_buf (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.in_valid_i(buf_push),
		.in_ready_o(buf_in_ready),
		.in_data_i(acc_rdata),
		.out_valid_o(buf_out_valid),
		.out_ready_i(buf_pop),
		.out_data_o(buf_data)
	);

	// ==============================
	// Interval counters
	logic [15:0] tcnt_reg [0:2];
	logic [15:0] tload_reg [0:2];
	logic [2:0] tarm_reg, tbcd_reg;
	logic [1:0] csel_reg;
	logic [PW-1:0] presc_reg;
	logic tick_f, tick_m, tick_s, tick, tmr_wr;
	// Prescaler taps give the three selectable rates
	assign tick_f = (int'(presc_reg) % F_CYC) == F_CYC - 1;
	assign tick_m = (int'(presc_reg) % M_CYC) == M_CYC - 1;
	assign tick_s = int'(presc_reg) == S_CYC - 1;
	assign tick = csel_reg == 2'h0 ? tick_f : csel_reg == 2'h1 ? tick_m : tick_s;
	assign tmr_wr = acc_ok && acc_wr && acc_tgt == pbd_pkg::TGT_TMR;
	assign tmr_rdata = tmr_ctl ? {3'h0, csel_reg, tbcd_reg}
		: acc_addr[0] ? tcnt_reg[tsel][15:8] : tcnt_reg[tsel][7:0];

	// Low byte disarms, high byte loads and starts; count reloads at zero
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			presc_reg <= '0;
			csel_reg <= 2'h0;
			tarm_reg <= 3'h0;
			tbcd_reg <= 3'h0;
			tmr_out_o <= 3'h0;
			for (int i = 0; i < 3; i++) begin
				tcnt_reg[i] <= 16'h0000;
				tload_reg[i] <= 16'h0000;
			end
		end else begin
			presc_reg <= presc_reg + 1'b1;
			if (tmr_wr && tmr_ctl) csel_reg <= acc_wdata[`PBD_CTL_CSEL];
			for (int i = 0; i < 3; i++) begin
				tmr_out_o[i] <= tarm_reg[i] && tick && tcnt_reg[i] == 16'h0000;
				if (tarm_reg[i] && tick) begin
					if (tcnt_reg[i] == 16'h0000) tcnt_reg[i] <= tload_reg[i];
					else tcnt_reg[i] <= dec16(tcnt_reg[i], tbcd_reg[i]);
				end
				if (tmr_wr && !tmr_ctl && tsel == 2'(i)) begin
					if (acc_addr[0]) begin
						tload_reg[i][15:8] <= acc_wdata;
						tcnt_reg[i] <= {acc_wdata, tload_reg[i][7:0]};
						tarm_reg[i] <= 1'b1;
					end else begin
						tload_reg[i][7:0] <= acc_wdata;
						tarm_reg[i] <= 1'b0;
					end
				end
				if (tmr_wr && tmr_ctl && acc_wdata[1:0] == 2'(i))
					tbcd_reg[i] <= acc_wdata[`PBD_CTL_BCD];
			end
		end
	end

	// ==============================
	// Channel requests and host interrupts; a new event wins over its clear
	logic [1:0] take_vec, irq_set;
	assign pick1 = pend_reg[1] && (!pend_reg[0] || !last_reg);
	assign take = in_idle && pend_reg != 2'h0;
	assign take_vec = take ? (pick1 ? 2'h2 : 2'h1) : 2'h0;
	assign irq_set = (in_stat && acc_ok && !chain_go) ? (chan_reg ? 2'h2 : 2'h1) : 2'h0;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pend_reg <= 2'h0;
			irq_reg <= 2'h0;
		end else begin
			pend_reg <= (pend_reg & ~take_vec) | chan_start_i;
			irq_reg <= (irq_reg & ~irq_ack_i) | irq_set;
		end
	end
	assign host_irq_o = irq_reg;
	assign busy_o = !in_idle;
	assign task_run_o = in_task;

	// Fetched block bytes
	always_ff @(posedge sys_clk_i) begin
		if (in_fetch && acc_ok) pb_reg[idx_reg] <= acc_rdata;
	end

	// ==============================
	// Command sequencer
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_reg <= pbd_pkg::ST_IDLE;
			idx_reg <= 5'h00;
			pb_base_reg <= 16'h0000;
			chan_reg <= 1'b0;
			last_reg <= 1'b1;
			k_reg <= 1'b0;
			unl_reg <= 1'b0;
			term_seen_reg <= 1'b0;
			status_reg <= 8'h00;
			xfer_reg <= 8'h00;
			cnt_reg <= 24'h0;
			saddr_reg <= 16'h0000;
			daddr_reg <= 16'h0000;
			task_addr_o <= 16'h0000;
		end else begin
			if (in_dma && term_lvl_reg) term_seen_reg <= 1'b1;
			if (acc_done && acc_refuse) begin
				status_reg <= `PBD_ST_REFUSED;
				state_reg <= pbd_pkg::ST_STATUS;
			end else begin
				case (state_reg)
				pbd_pkg::ST_IDLE: begin
					if (take) begin
						chan_reg <= pick1;
						last_reg <= pick1;
						pb_base_reg <= pick1 ? CH1_PB : CH0_PB;
						idx_reg <= 5'h00;
						state_reg <= pbd_pkg::ST_FETCH;
					end
				end
				pbd_pkg::ST_FETCH: begin
					if (acc_ok) begin
						if (idx_reg == `PBD_PB_LAST) state_reg <= pbd_pkg::ST_DECODE;
						else idx_reg <= idx_reg + 5'h01;
					end
				end
				pbd_pkg::ST_DECODE: begin
					k_reg <= 1'b0;
					status_reg <= `PBD_ST_OK;
					case (pb_reg[`PBD_PB_CMD])
					`PBD_CMD_CHECK: state_reg <= pbd_pkg::ST_STATUS;
					`PBD_CMD_RWR: state_reg <= pbd_pkg::ST_REG_WR;
					`PBD_CMD_RRD: state_reg <= pbd_pkg::ST_REG_RD;
					`PBD_CMD_DMA: begin
						cnt_reg <= {pb_reg[`PBD_PB_CNT+5'h02], pb_reg[`PBD_PB_CNT+5'h01],
							pb_reg[`PBD_PB_CNT]};
						unl_reg <= {pb_reg[`PBD_PB_CNT+5'h02], pb_reg[`PBD_PB_CNT+5'h01],
							pb_reg[`PBD_PB_CNT]} == 24'h0;
						saddr_reg <= src_addr;
						daddr_reg <= dst_addr;
						term_seen_reg <= 1'b0;
						state_reg <= pbd_pkg::ST_DMA_PICK;
					end
					`PBD_CMD_TASK: begin
						task_addr_o <= src_addr;
						state_reg <= pbd_pkg::ST_TASK;
					end
					default: begin
						status_reg <= `PBD_ST_BADCMD;
						state_reg <= pbd_pkg::ST_STATUS;
					end
					endcase
				end
				pbd_pkg::ST_REG_RD: begin
					if (acc_ok) begin
						xfer_reg <= acc_rdata;
						state_reg <= pbd_pkg::ST_REG_WR;
					end
				end
				pbd_pkg::ST_REG_WR: begin
					if (acc_ok) begin
						if (word_op && !k_reg) begin
							k_reg <= 1'b1; // Second byte of a word
							state_reg <= rd_cmd ? pbd_pkg::ST_REG_RD : pbd_pkg::ST_REG_WR;
						end else state_reg <= pbd_pkg::ST_STATUS;
					end
				end
				pbd_pkg::ST_DMA_PICK: begin
					// Reads run ahead while the buffer has room, writes drain it
					if (rd_more && buf_in_ready) state_reg <= pbd_pkg::ST_DMA_RD;
					else if (buf_out_valid) state_reg <= pbd_pkg::ST_DMA_WR;
					else state_reg <= pbd_pkg::ST_STATUS;
				end
				pbd_pkg::ST_DMA_RD: begin
					if (acc_ok) begin
						if (!src_io) saddr_reg <= saddr_reg + 16'h0001;
						if (!unl_reg) cnt_reg <= cnt_reg - 24'h1;
						state_reg <= pbd_pkg::ST_DMA_PICK;
					end
				end
				pbd_pkg::ST_DMA_WR: begin
					if (acc_ok) begin
						if (!dst_io) daddr_reg <= daddr_reg + 16'h0001;
						state_reg <= pbd_pkg::ST_DMA_PICK;
					end
				end
				pbd_pkg::ST_TASK: begin
					if (task_done_i) state_reg <= pbd_pkg::ST_STATUS;
				end
				pbd_pkg::ST_STATUS: begin
					if (acc_ok) begin
						if (chain_go) begin
							pb_base_reg <= chain_ptr;
							idx_reg <= 5'h00;
							state_reg <= pbd_pkg::ST_FETCH;
						end else state_reg <= pbd_pkg::ST_IDLE;
					end
				end
				default: state_reg <= pbd_pkg::ST_IDLE;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// file: test/pbd_cmd_unit_props.sv
// Port checks for the parameter block command unit
`default_nettype none
module pbd_cmd_unit_props #(
	parameter logic [19:0] WIN_BASE = 20'h00000
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire pbd_pkg::pbd_host_req_s host_i,
	input wire logic host_hit_o,
	input wire logic [1:0] irq_ack_i,
	input wire logic [1:0] host_irq_o,
	input wire logic lbus_req_o,
	input wire pbd_pkg::pbd_lbus_req_s lbus_o,
	input wire logic lbus_ack_i,
	input wire logic task_run_o,
	input wire logic task_done_i,
	input wire logic [2:0] tmr_out_o,
	input wire logic busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Local bus address classes
	wire logic [15:0] la = lbus_o.addr;
	wire logic misc = (la >= 16'hffc0 && la <= 16'hffc6) || (la >= 16'hfff0 && la <= 16'hfffe);
	wire logic tmr = la >= 16'hffc8 && la <= 16'hffce;
	wire logic io_req = lbus_req_o && lbus_o.io;
	// One clock domain, so reset cancels every check
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);
	chk_win_decode: assert property (host_hit_o == (host_i.addr[19:13] == WIN_BASE[19:13]))
		else $error("window decode wrong");
	chk_ram_inside: assert property (lbus_req_o && !lbus_o.io |-> la > 16'h1fff)
		else $error("on-board RAM address left the board");
	chk_misc_flag: assert property (io_req |-> lbus_o.misc == misc)
		else $error("misc decode wrong");
	chk_tmr_inside: assert property (io_req |-> !tmr)
		else $error("timer access went outside");
	chk_req_hold: assert property (lbus_req_o && !lbus_ack_i |=> lbus_req_o && $stable(lbus_o))
		else $error("bus request changed before ack");
	chk_irq_sticky: assert property (host_irq_o[0] && !irq_ack_i[0] |=> host_irq_o[0])
		else $error("interrupt dropped without ack");
	chk_irq_after_run: assert property ($rose(host_irq_o[1]) |-> $past(busy_o))
		else $error("interrupt without a run");
	chk_task_wait: assert property (task_run_o && !task_done_i |=> task_run_o)
		else $error("task left before return");
	chk_tmr_pulse: assert property (tmr_out_o != 3'h0 |=> tmr_out_o == 3'h0)
		else $error("timer pulse too long");
	chk_idle_quiet: assert property (!busy_o |-> !lbus_req_o && !task_run_o)
		else $error("activity while idle");
endmodule
bind pbd_cmd_unit pbd_cmd_unit_props #(.WIN_BASE(WIN_BASE)) u_props (.sys_clk_i, .rst_i,
	.host_i, .host_hit_o, .irq_ack_i, .host_irq_o, .lbus_req_o, .lbus_o, .lbus_ack_i,
	.task_run_o, .task_done_i, .tmr_out_o, .busy_o);
`default_nettype wire

// file: test/pbd_lbus_dev.sv
// Local bus device model: byte registers with an optional wait
`default_nettype none
module pbd_lbus_dev (
	input wire logic sys_clk_i,
	input wire logic slow_i,
	input wire logic req_i,
	input wire pbd_pkg::pbd_lbus_req_s bus_i,
	output logic ack_o,
	output logic [7:0] rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [256];
	logic [7:0] last_reg = 8'h00;
	logic [1:0] wait_reg = 2'h0;
	// ==========
	// Slow mode adds two wait states before the ack
	assign ack_o = req_i && (!slow_i || wait_reg == 2'h2);
	// Released data flips every cycle so a late sample never matches
	assign rdata_o = ack_o ? mem[bus_i.addr[7:0]] : ~last_reg;
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h5a;
	end
	// Writes land on the acknowledged edge only; plain always since the array is preloaded
	always @(posedge sys_clk_i) begin
		last_reg <= rdata_o;
		wait_reg <= (req_i && !ack_o) ? wait_reg + 2'h1 : 2'h0;
		if (ack_o && bus_i.wr)
			mem[bus_i.addr[7:0]] <= bus_i.wdata;
	end
endmodule
`default_nettype wire

// file: test/tb_pbd_cmd_unit.sv
// Self-checking bench for the parameter block command unit
`default_nettype none
module tb_pbd_cmd_unit;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	pbd_pkg::pbd_host_req_s host_i = '0;
	logic [1:0] chan_start_i = 2'h0;
	logic [1:0] irq_ack_i = 2'h0;
	logic dma_term_i = 1'b0;
	logic task_done_i = 1'b0;
	logic slow = 1'b0;
	logic host_hit_o, lbus_req_o, lbus_ack_i, task_run_o, busy_o;
	logic [7:0] host_rdata_o, lbus_rdata_i;
	logic [1:0] host_irq_o;
	logic [2:0] tmr_out_o;
	logic [15:0] task_addr_o;
	pbd_pkg::pbd_lbus_req_s lbus_o;
	int err_total = 0;
	int compares = 0;
	int n;
	pbd_cmd_unit DUT (.sys_clk_i, .rst_i, .host_i, .host_hit_o, .host_rdata_o, .chan_start_i,
		.irq_ack_i, .host_irq_o, .lbus_req_o, .lbus_o, .lbus_ack_i, .lbus_rdata_i, .dma_term_i,
		.task_run_o, .task_addr_o, .task_done_i, .tmr_out_o, .busy_o);
	pbd_lbus_dev lbus (.sys_clk_i, .slow_i(slow), .req_i(lbus_req_o), .bus_i(lbus_o),
		.ack_o(lbus_ack_i), .rdata_o(lbus_rdata_i));
	// ==========
	// Clock, 25 ns period
	initial begin
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	task automatic end_sim;
		if (err_total == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	// Host writes hold the strobe; the caller drops it once
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		host_i = '{20'(a), 1'b0, 1'b1, d};
		@(negedge sys_clk_i);
	endtask
	task automatic mem_is(input logic [12:0] a, input logic [7:0] e);
		host_i = '{20'(a), 1'b1, 1'b0, 8'h00};
		@(negedge sys_clk_i);
		check("window hit", 16'(host_hit_o), 16'h1);
		check("ram byte", {8'h00, host_rdata_o}, {8'h00, e});
		host_i = '0;
		@(negedge sys_clk_i);
	endtask
	task automatic fill(input logic [12:0] a, input logic [31:0] v);
		for (int i = 0; i < 4; i++)
			wr(a + 13'(i), v[8*i +: 8]);
		host_i = '0;
		@(negedge sys_clk_i);
	endtask
	task automatic blk(input logic [12:0] a, input logic [7:0] c, input logic [15:0] ch,
		input logic [7:0] sd, st, input logic [15:0] sr, sx, input logic [7:0] dd, dt,
		input logic [15:0] dr, dp, input logic [23:0] cnt);
		logic [151:0] v;
		v = {cnt, dp, dr, dt, dd, sx, sr, st, sd, ch, 8'h00, c};
		for (int i = 0; i < 19; i++)
			wr(a + 13'(i), v[8*i +: 8]);
		host_i = '0;
		@(negedge sys_clk_i);
	endtask
	task automatic go(input int ch);
		chan_start_i[ch] = 1'b1;
		@(negedge sys_clk_i);
		chan_start_i = 2'h0;
	endtask
	task automatic fin(input int ch);
		n = 0;
		while (host_irq_o[ch] !== 1'b1 && n < 3000) begin
			@(negedge sys_clk_i);
			n++;
		end
		check("interrupt", 16'(host_irq_o), 16'(1 << ch));
		irq_ack_i[ch] = 1'b1;
		@(negedge sys_clk_i);
		irq_ack_i = 2'h0;
		@(negedge sys_clk_i);
	endtask
	task automatic run(input int ch);
		go(ch);
		fin(ch);
	endtask
	task automatic t_cmds;
		host_i = '{20'h02100, 1'b1, 1'b0, 8'h00};
		@(negedge sys_clk_i);
		check("window miss", 16'(host_hit_o), 16'h0);
		blk(13'h100, 8'h00, 16'h0, 8'h0, 8'h0, 16'h0, 16'h0, 8'h0, 8'h0, 16'h0, 16'h0, 24'h0);
		blk(13'h140, 8'h77, 16'h0, 8'h0, 8'h0, 16'h0, 16'h0, 8'h0, 8'h0, 16'h0, 16'h0, 24'h0);
		run(0);
		mem_is(13'h101, 8'h01);
		run(1);
		mem_is(13'h141, 8'h80);
		// Engine may write the firmware area, the host may not
		blk(13'h100, 8'h01, 16'h0, 8'h0, 8'h0, 16'h0, 16'h3c, 8'h0, 8'h0, 16'h0, 16'h10, 24'h0);
		run(0);
		wr(13'h010, 8'ha5);
		mem_is(13'h010, 8'h3c);
	endtask
	// Slow device on the writes, fast one on the word read
	task automatic t_regs;
		slow = 1'b1;
		blk(13'h100, 8'h01, 16'h0, 8'h1, 8'h0, 16'hff80, 16'h3c, 8'h1, 8'h0, 16'hff80, 16'h0, 24'h0);
		run(0);
		check("dev reg", {8'h00, lbus.mem[8'h80]}, 16'h003c);
		blk(13'h100, 8'h01, 16'h0, 8'h1, 8'h0, 16'hffc8, 16'h5, 8'h1, 8'h0, 16'hffc8, 16'h0, 24'h0);
		run(0);
		mem_is(13'h101, 8'h81);
		slow = 1'b0;
		blk(13'h140, 8'h02, 16'h0, 8'h1, 8'h1, 16'hff90, 16'h0, 8'h1, 8'h1, 16'hff90, 16'h0, 24'h0);
		run(1);
		mem_is(13'h148, 8'hca);
		mem_is(13'h149, 8'hcb);
	endtask
	task automatic t_dma;
		fill(13'h400, 32'h44332211);
		fill(13'h500, 32'h0);
		blk(13'h180, 8'h00, 16'h0, 8'h0, 8'h0, 16'h0, 16'h0, 8'h0, 8'h0, 16'h0, 16'h0, 24'h0);
		blk(13'h100, 8'h03, 16'h180, 8'h0, 8'h0, 16'h400, 16'h0, 8'h0, 8'h0, 16'h0, 16'h500, 24'h3);
		run(0);
		mem_is(13'h502, 8'h33);
		mem_is(13'h503, 8'h00);
		mem_is(13'h181, 8'h01);
	endtask
	task automatic t_free;
		fill(13'h600, 32'h0);
		blk(13'h100, 8'h03, 16'h0, 8'h0, 8'h0, 16'h400, 16'h0, 8'h0, 8'h0, 16'h0, 16'h600, 24'h0);
		go(0);
		repeat (200) @(negedge sys_clk_i);
		check("busy", 16'(busy_o), 16'h1);
		dma_term_i = 1'b1;
		fin(0);
		dma_term_i = 1'b0;
		mem_is(13'h603, 8'h44);
	endtask
	task automatic t_task;
		blk(13'h100, 8'h04, 16'h0, 8'h0, 8'h0, 16'h1234, 16'h0, 8'h0, 8'h0, 16'h0, 16'h0, 24'h0);
		go(0);
		repeat (100) @(negedge sys_clk_i);
		check("task addr", task_addr_o, 16'h1234);
		check("task run", 16'(task_run_o), 16'h1);
		task_done_i = 1'b1;
		@(negedge sys_clk_i);
		task_done_i = 1'b0;
		fin(0);
	endtask
	// Counter 1 loaded with 2 at the fast tick: 2, 1, 0 then reload, so a pulse every 96 cycles
	task automatic t_timer;
		blk(13'h100, 8'h01, 16'h180, 8'h1, 8'h1, 16'hffca, 16'h2, 8'h1, 8'h1, 16'hffca, 16'h0, 24'h0);
		run(0);
		n = 0;
		while (tmr_out_o[1] !== 1'b1 && n < 200) begin
			@(negedge sys_clk_i);
			n++;
		end
		@(negedge sys_clk_i);
		n = 1;
		while (tmr_out_o[1] !== 1'b1 && n < 200) begin
			@(negedge sys_clk_i);
			n++;
		end
		check("period", 16'(n), 16'h60);
	endtask
	initial begin
		repeat (5) @(negedge sys_clk_i);
		rst_i = 1'b0;
		t_cmds();
		t_regs();
		t_dma();
		t_free();
		t_task();
		t_timer();
		end_sim();
	end
	// Watchdog well beyond the expected run
	initial begin
		repeat (30000) @(posedge sys_clk_i);
		err_total++;
		end_sim();
	end
endmodule
`default_nettype wire
